// ===== rrsa_alu.sv
// Purpose: Execution datapath for rotate-right and subtract-with-borrow operations
// Assumes: Decode presents one operation per op_valid pulse with its operands
// Notes: Results and flags appear one clock after the request
// Contract
// - Plain rotate to memory moves bit 0 to bit 7, writes memory, and keeps all flags.
// - Plain rotate to accumulator writes the rotated byte to the accumulator only.
// - Rotate through carry to memory rotates the nine-bit ring of byte and carry.
// - Rotate through carry to accumulator writes the accumulator and loads bit 0 into carry.
// - The through-carry rotates change only carry; no rotate touches other flags.
// - Subtract to accumulator computes accumulator minus memory minus inverted carry.
// - Subtract to memory computes the same difference and writes it to memory.
// - After a subtract, carry is 0 for a negative result and 1 otherwise.
// - Subtracts update wrap, null, half borrow, carry, signed borrow and extended null.
`timescale 1ns/100ps
module rrsa_alu (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic op_valid,
    input wire logic [rrsa_pkg::OP_W-1:0] op_code,
    input wire logic [rrsa_pkg::DATA_W-1:0] mem_data,
    input wire logic [rrsa_pkg::DATA_W-1:0] acc_data,
    input wire logic borrow_out_bit,
    input wire logic extended_null_flag,
    output logic res_valid,
    output logic [rrsa_pkg::DATA_W-1:0] res_data,
    output logic acc_we,
    output logic mem_we,
    output logic carry_we,
    output logic arith_we,
    output logic borrow_out_bit_new,
    output logic signed_wrap_flag,
    output logic result_null_flag,
    output logic half_borrow_flag,
    output logic signed_borrow_flag,
    output logic extended_null_flag_new
);
    rrsa_sub_if sub_bus ();

    rrsa_sub_unit u_sub (
        .sub(sub_bus.unit)
    );

    wire is_rr_mem;
    wire is_rr_acc;
    wire is_rrc_mem;
    wire is_rrc_acc;
    wire is_sbc_acc;
    wire is_sbc_mem;
    wire is_rotate;
    wire is_through;
    wire is_sub;
    wire [7:0] rot_plain;
    wire [7:0] rot_carry;
    wire [7:0] result_sel;
    wire take_mem;
    wire take_acc;
    wire upd_data;
    wire upd_carry;
    wire upd_arith;
    wire carry_sel;

    logic res_valid_reg;
    logic [7:0] res_data_reg;
    logic acc_we_reg;
    logic mem_we_reg;
    logic carry_we_reg;
    logic arith_we_reg;
    logic carry_reg;
    logic wrap_reg;
    logic null_reg;
    logic half_reg;
    logic sign_reg;
    logic ext_null_reg;
    logic res_valid_next;
    logic [7:0] res_data_next;
    logic acc_we_next;
    logic mem_we_next;
    logic carry_we_next;
    logic arith_we_next;
    logic carry_next;
    logic wrap_next;
    logic null_next;
    logic half_next;
    logic sign_next;
    logic ext_null_next;

    assign is_rr_mem = op_valid && (op_code == rrsa_pkg::OP_ROTATE_RIGHT_MEM);
    assign is_rr_acc = op_valid && (op_code == rrsa_pkg::OP_ROTATE_RIGHT_TO_ACC);
    assign is_rrc_mem = op_valid && (op_code == rrsa_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY_MEM);
    assign is_rrc_acc = op_valid && (op_code == rrsa_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY_TO_ACC);
    assign is_sbc_acc = op_valid && (op_code == rrsa_pkg::OP_SUB_BORROW_TO_ACC);
    assign is_sbc_mem = op_valid && (op_code == rrsa_pkg::OP_SUB_BORROW_TO_MEM);
    assign is_through = is_rrc_mem || is_rrc_acc;
    assign is_rotate = is_rr_mem || is_rr_acc || is_through;
    assign is_sub = is_sbc_acc || is_sbc_mem;

    assign sub_bus.minuend = acc_data;
    assign sub_bus.subtrahend = mem_data;
    assign sub_bus.carry_in = borrow_out_bit;
    assign sub_bus.ext_null_in = extended_null_flag;

    // Bits 6 down to 0 take their left neighbour in both rotate forms
    genvar bit_idx;
    generate
        for (bit_idx = 0; bit_idx < rrsa_pkg::MSB_POS; bit_idx = bit_idx + 1) begin : g_rot_bit
            assign rot_plain[bit_idx] = mem_data[bit_idx + 1];
            assign rot_carry[bit_idx] = mem_data[bit_idx + 1];
        end
    endgenerate
    // Bit 7 is where the forms differ: old bit 0, or the incoming carry
    assign rot_plain[rrsa_pkg::MSB_POS] = mem_data[rrsa_pkg::LSB_POS];
    assign rot_carry[rrsa_pkg::MSB_POS] = borrow_out_bit;

    assign result_sel = is_sub ? sub_bus.diff
        : (is_through ? rot_carry : rot_plain);
    // Destination picks memory or accumulator; unknown codes write nothing
    assign take_mem = is_rr_mem || is_rrc_mem || is_sbc_mem;
    assign take_acc = is_rr_acc || is_rrc_acc || is_sbc_acc;

    // Old bit 0 becomes the carry for either through-carry rotate
    assign carry_sel = is_sub ? sub_bus.carry_out
        : mem_data[rrsa_pkg::LSB_POS];

    // A refused code raises no strobe and leaves every held output alone
    assign upd_data = is_rotate || is_sub;
    assign upd_carry = is_through || is_sub;
    assign upd_arith = is_sub;

    assign res_valid_next = take_mem || take_acc;
    assign acc_we_next = take_acc;
    assign mem_we_next = take_mem;
    // Plain rotates raise no flag strobe at all
    assign carry_we_next = upd_carry;
    assign arith_we_next = upd_arith;

    // Data and flags hold between operations so a late reader still sees them
    assign res_data_next = upd_data ? result_sel : res_data_reg;
    assign carry_next = upd_carry ? carry_sel : carry_reg;
    assign wrap_next = upd_arith ? sub_bus.wrap_out : wrap_reg;
    assign null_next = upd_arith ? sub_bus.null_out : null_reg;
    assign half_next = upd_arith ? sub_bus.half_out : half_reg;
    assign sign_next = upd_arith ? sub_bus.sign_out : sign_reg;
    assign ext_null_next = upd_arith ? sub_bus.ext_null_out : ext_null_reg;

    // One short register per output keeps each reset value beside its flop
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            res_valid_reg <= rrsa_pkg::FLAG_RESET;
        end else begin
            res_valid_reg <= res_valid_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            acc_we_reg <= rrsa_pkg::FLAG_RESET;
        end else begin
            acc_we_reg <= acc_we_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mem_we_reg <= rrsa_pkg::FLAG_RESET;
        end else begin
            mem_we_reg <= mem_we_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            carry_we_reg <= rrsa_pkg::FLAG_RESET;
        end else begin
            carry_we_reg <= carry_we_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            arith_we_reg <= rrsa_pkg::FLAG_RESET;
        end else begin
            arith_we_reg <= arith_we_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            res_data_reg <= rrsa_pkg::RESULT_RESET;
        end else begin
            res_data_reg <= res_data_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            carry_reg <= rrsa_pkg::FLAG_RESET;
        end else begin
            carry_reg <= carry_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wrap_reg <= rrsa_pkg::FLAG_RESET;
        end else begin
            wrap_reg <= wrap_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            null_reg <= rrsa_pkg::FLAG_RESET;
        end else begin
            null_reg <= null_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            half_reg <= rrsa_pkg::FLAG_RESET;
        end else begin
            half_reg <= half_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sign_reg <= rrsa_pkg::FLAG_RESET;
        end else begin
            sign_reg <= sign_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ext_null_reg <= rrsa_pkg::FLAG_RESET;
        end else begin
            ext_null_reg <= ext_null_next;
        end
    end

    assign res_valid = res_valid_reg;
    assign res_data = res_data_reg;
    assign acc_we = acc_we_reg;
    assign mem_we = mem_we_reg;
    assign carry_we = carry_we_reg;
    assign arith_we = arith_we_reg;
    assign borrow_out_bit_new = carry_reg;
    assign signed_wrap_flag = wrap_reg;
    assign result_null_flag = null_reg;
    assign half_borrow_flag = half_reg;
    assign signed_borrow_flag = sign_reg;
    assign extended_null_flag_new = ext_null_reg;
endmodule : rrsa_alu

// ===== rrsa_pkg.sv
// Purpose: Shared constants for the rotate-right / subtract-with-borrow datapath
// Assumes: Eight-bit core datapath, one result per accepted operation
// Notes: Operation codes are local to this block
package rrsa_pkg;
    localparam int DATA_W = 8;
    localparam int MSB_POS = 7;
    localparam int LSB_POS = 0;
    localparam int NIB_W = 4;
    localparam int OP_W = 3;
    localparam logic [2:0] OP_ROTATE_RIGHT_MEM = 3'h0;
    localparam logic [2:0] OP_ROTATE_RIGHT_TO_ACC = 3'h1;
    localparam logic [2:0] OP_ROTATE_RIGHT_THROUGH_CARRY_MEM = 3'h2;
    localparam logic [2:0] OP_ROTATE_RIGHT_THROUGH_CARRY_TO_ACC = 3'h3;
    localparam logic [2:0] OP_SUB_BORROW_TO_ACC = 3'h4;
    localparam logic [2:0] OP_SUB_BORROW_TO_MEM = 3'h5;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic FLAG_RESET = 1'b0;
    localparam int LATENCY_CYCLES = 1;
endpackage : rrsa_pkg

// ===== rrsa_sub_if.sv
// Purpose: Carrier between the datapath top and its subtract unit
// Assumes: Purely combinational traffic on the core clock
// Notes: The unit drives every flag, the top drives the operands
`timescale 1ns/100ps
interface rrsa_sub_if;
    logic [7:0] minuend;
    logic [7:0] subtrahend;
    logic carry_in;
    logic ext_null_in;
    logic [7:0] diff;
    logic carry_out;
    logic half_out;
    logic wrap_out;
    logic null_out;
    logic sign_out;
    logic ext_null_out;
    modport unit (
        input minuend,
        input subtrahend,
        input carry_in,
        input ext_null_in,
        output diff,
        output carry_out,
        output half_out,
        output wrap_out,
        output null_out,
        output sign_out,
        output ext_null_out
    );
    modport user (
        output minuend,
        output subtrahend,
        output carry_in,
        output ext_null_in,
        input diff,
        input carry_out,
        input half_out,
        input wrap_out,
        input null_out,
        input sign_out,
        input ext_null_out
    );
endinterface : rrsa_sub_if

// ===== rrsa_sub_unit.sv
// Purpose: Eight-bit subtract with borrow and its status flags
// Assumes: Carry set means no borrow, as for the core's other subtracts
// Notes: Combinational; the top registers every result
`timescale 1ns/100ps
module rrsa_sub_unit (
    rrsa_sub_if.unit sub
);
    wire [8:0] full_diff;
    wire [4:0] low_diff;
    wire borrow_in;

    // Inverted carry is the borrow that enters bit 0
    assign borrow_in = ~sub.carry_in;
    assign full_diff = {1'b0, sub.minuend} - {1'b0, sub.subtrahend} - {8'h00, borrow_in};
    assign low_diff = {1'b0, sub.minuend[rrsa_pkg::NIB_W-1:0]}
        - {1'b0, sub.subtrahend[rrsa_pkg::NIB_W-1:0]} - {4'h0, borrow_in};
    assign sub.diff = full_diff[rrsa_pkg::DATA_W-1:0];
    // Borrow out of bit 7 means a negative result, so carry clears
    assign sub.carry_out = ~full_diff[rrsa_pkg::DATA_W];
    assign sub.half_out = ~low_diff[rrsa_pkg::NIB_W];
    assign sub.wrap_out = (sub.minuend[rrsa_pkg::MSB_POS] ^ sub.subtrahend[rrsa_pkg::MSB_POS])
        & (sub.minuend[rrsa_pkg::MSB_POS] ^ full_diff[rrsa_pkg::MSB_POS]);
    assign sub.null_out = (full_diff[rrsa_pkg::DATA_W-1:0] == 8'h00);
    // True sign of the difference even when the eight-bit result wraps
    assign sub.sign_out = sub.wrap_out ^ full_diff[rrsa_pkg::MSB_POS];
    // Multi-byte zero: stays set only while every byte so far was zero
    assign sub.ext_null_out = sub.null_out & sub.ext_null_in;
endmodule : rrsa_sub_unit

// ===== rrsa_alu_properties.sv
// Purpose: Port properties of the rotate and subtract datapath
// Assumes: One-cycle answer after a taken request
// Notes: Bound to rrsa_alu below
`timescale 1ns/100ps
module rrsa_alu_chk (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic op_valid,
    input wire logic [2:0] op_code,
    input wire logic [7:0] mem_data,
    input wire logic [7:0] acc_data,
    input wire logic borrow_out_bit,
    input wire logic extended_null_flag,
    input wire logic res_valid,
    input wire logic [7:0] res_data,
    input wire logic acc_we,
    input wire logic mem_we,
    input wire logic carry_we,
    input wire logic arith_we,
    input wire logic borrow_out_bit_new,
    input wire logic signed_wrap_flag,
    input wire logic result_null_flag,
    input wire logic half_borrow_flag,
    input wire logic signed_borrow_flag,
    input wire logic extended_null_flag_new
);
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    wire logic [7:0] hit_w = {7'h00, op_valid} << op_code;
    wire logic [3:0] we_w = {acc_we, mem_we, carry_we, arith_we};
    wire logic [7:0] rot_w = {mem_data[0], mem_data[7:1]};
    wire logic [7:0] rrc_w = {borrow_out_bit, mem_data[7:1]};
    wire logic [4:0] fl_w = {signed_wrap_flag, result_null_flag, half_borrow_flag,
        signed_borrow_flag, extended_null_flag_new};
    wire logic [8:0] dif_w = {1'b0, acc_data} - {1'b0, mem_data} - {8'h00, ~borrow_out_bit};
    wire logic sub_w = hit_w[4] | hit_w[5];
    wire logic [4:0] nib_w = {1'h0, acc_data[3:0]} - {1'h0, mem_data[3:0]}
        - {4'h0, ~borrow_out_bit};
    wire logic ovf_w = (acc_data[7] ^ mem_data[7]) & (acc_data[7] ^ dif_w[7]);
    rot_mem_a: assert property (hit_w[0] |=>
        res_valid && we_w == 4'h4 && res_data == $past(rot_w)) else $error("rot mem");
    rot_acc_a: assert property (hit_w[1] |=>
        res_valid && we_w == 4'h8 && res_data == $past(rot_w)) else $error("rot acc");
    rrc_mem_a: assert property (hit_w[2] |=> we_w == 4'h6 &&
        res_data == $past(rrc_w) && borrow_out_bit_new == $past(mem_data[0])) else $error("rrc");
    rrc_acc_a: assert property (hit_w[3] |=> we_w == 4'ha &&
        res_data == $past(rrc_w) && borrow_out_bit_new == $past(mem_data[0])) else $error("rrca");
    rot_flags_a: assert property (|hit_w[3:0] |=> $stable(fl_w))
        else $error("rotate flags");
    sub_res_a: assert property (sub_w |=> carry_we && arith_we &&
        mem_we == $past(op_code[0]) && acc_we != mem_we && res_data == $past(dif_w[7:0]))
        else $error("sub result");
    sub_carry_a: assert property (sub_w |=> borrow_out_bit_new == !$past(dif_w[8]))
        else $error("sub carry");
    sub_flags_a: assert property (sub_w |=> result_null_flag == (res_data == 8'h00) &&
        signed_borrow_flag == (signed_wrap_flag ^ res_data[7]) &&
        extended_null_flag_new == (result_null_flag && $past(extended_null_flag)))
        else $error("sub flags");
    sub_wrap_a: assert property (sub_w |=>
        signed_wrap_flag == $past(ovf_w) && half_borrow_flag == !$past(nib_w[4]))
        else $error("sub wrap or half borrow");
    no_req_a: assert property (!(|hit_w[5:0]) |=> !res_valid && we_w == 4'h0)
        else $error("stray strobe");
    cover property (hit_w[2] ##1 borrow_out_bit_new);
    cover property (sub_w ##1 !borrow_out_bit_new);
    cover property (sub_w ##1 extended_null_flag_new);
endmodule : rrsa_alu_chk
bind rrsa_alu rrsa_alu_chk chk (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .op_valid(op_valid),
    .op_code(op_code),
    .mem_data(mem_data),
    .acc_data(acc_data),
    .borrow_out_bit(borrow_out_bit),
    .extended_null_flag(extended_null_flag),
    .res_valid(res_valid),
    .res_data(res_data),
    .acc_we(acc_we),
    .mem_we(mem_we),
    .carry_we(carry_we),
    .arith_we(arith_we),
    .borrow_out_bit_new(borrow_out_bit_new),
    .signed_wrap_flag(signed_wrap_flag),
    .result_null_flag(result_null_flag),
    .half_borrow_flag(half_borrow_flag),
    .signed_borrow_flag(signed_borrow_flag),
    .extended_null_flag_new(extended_null_flag_new)
);

// ===== rrsa_alu_bench.sv
// Purpose: Directed bench for the rotate and subtract datapath
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Flags are tracked here, so a stray update shows on later checks
`timescale 1ns/100ps
module rrsa_alu_bench;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic op_valid = 1'b0;
    logic [2:0] op_code = 3'h0;
    logic [7:0] mem_data = 8'h00;
    logic [7:0] acc_data = 8'h00;
    logic borrow_out_bit = 1'b0;
    logic extended_null_flag = 1'b0;
    logic res_valid, acc_we, mem_we, carry_we, arith_we, borrow_out_bit_new, signed_wrap_flag;
    logic result_null_flag, half_borrow_flag, signed_borrow_flag, extended_null_flag_new;
    logic [7:0] res_data;
    logic [7:0] exp_r = 8'h00;
    logic [5:0] exp_f = 6'h00;
    int failures = 0;
    int checks_done = 0;
    always #20 clk_sys = ~clk_sys;
    rrsa_alu dut (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .op_valid(op_valid),
        .op_code(op_code),
        .mem_data(mem_data),
        .acc_data(acc_data),
        .borrow_out_bit(borrow_out_bit),
        .extended_null_flag(extended_null_flag),
        .res_valid(res_valid),
        .res_data(res_data),
        .acc_we(acc_we),
        .mem_we(mem_we),
        .carry_we(carry_we),
        .arith_we(arith_we),
        .borrow_out_bit_new(borrow_out_bit_new),
        .signed_wrap_flag(signed_wrap_flag),
        .result_null_flag(result_null_flag),
        .half_borrow_flag(half_borrow_flag),
        .signed_borrow_flag(signed_borrow_flag),
        .extended_null_flag_new(extended_null_flag_new)
    );
    task automatic issue(input logic [2:0] op, input logic [7:0] a, input logic [7:0] m,
        input logic c, input logic z, input logic [3:0] we, input logic v = 1'b1);
        logic [18:0] got;
        op_valid = v;
        op_code = op;
        acc_data = a;
        mem_data = m;
        borrow_out_bit = c;
        extended_null_flag = z;
        @(posedge clk_sys);
        #1;
        got = {res_valid, res_data, acc_we, mem_we, carry_we, arith_we, borrow_out_bit_new,
            signed_wrap_flag, result_null_flag, half_borrow_flag, signed_borrow_flag,
            extended_null_flag_new};
        checks_done++;
        if (got !== {|we, exp_r, we, exp_f}) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, {|we, exp_r, we, exp_f});
        end
    endtask : issue
    // Unused codes must raise no strobe and leave every held output as it was
    task automatic test_refused();
        issue(3'h6, 8'h12, 8'h34, 1'b0, 1'b0, 4'h0);
        issue(3'h7, 8'h56, 8'h78, 1'b1, 1'b1, 4'h0);
        // A legal code without the strobe is not taken either
        issue(3'h4, 8'h9a, 8'hbc, 1'b0, 1'b1, 4'h0, 1'b0);
    endtask : test_refused
    // A mid-run reset clears every held output and loses the request it overlaps
    task automatic test_reset();
        rst_b = 1'b0;
        exp_r = 8'h00;
        exp_f = 6'h00;
        issue(3'h4, 8'h10, 8'h01, 1'b1, 1'b1, 4'h0);
        rst_b = 1'b1;
    endtask : test_reset
    task automatic test_sub();
        logic [17:0] t [8] = '{{8'h10, 8'h01, 2'b11}, {8'h00, 8'h01, 2'b11},
            {8'h80, 8'h01, 2'b11}, {8'h10, 8'h0f, 2'b01}, {8'h7f, 8'hff, 2'b10},
            {8'hff, 8'hff, 2'b11}, {8'h00, 8'h00, 2'b00}, {8'h7f, 8'h80, 2'b11}};
        logic [8:0] d;
        logic [4:0] h;
        logic ov;
        foreach (t[k]) begin
            d = {1'b0, t[k][17:10]} - {1'b0, t[k][9:2]} - {8'h00, ~t[k][1]};
            h = {1'b0, t[k][13:10]} - {1'b0, t[k][5:2]} - {4'h0, ~t[k][1]};
            ov = (t[k][17] ^ t[k][9]) & (d[7] ^ t[k][17]);
            exp_r = d[7:0];
            exp_f = {~d[8], ov, d[7:0] == 8'h00, ~h[4], ov ^ d[7], d[7:0] == 8'h00 && t[k][0]};
            issue(3'(4 + k % 2), t[k][17:10], t[k][9:2], t[k][1], t[k][0],
                {~k[0], k[0], 2'b11});
        end
    endtask : test_sub
    // First run follows the subtracts so the untouched wrap and half borrow flags are non-zero; the second follows reset, with them zero
    task automatic test_rotate();
        logic [7:0] m;
        for (int i = 0; i < 16; i++) begin
            m = 8'(i * 53 + 1);
            exp_r = {i[1] ? i[2] : m[0], m[7:1]};
            if (i[1]) exp_f[5] = m[0];
            issue(3'(i % 4), ~m, m, i[2], i[3],
                {i[0], ~i[0], i[1], 1'b0});
        end
    endtask : test_rotate
    task automatic end_of_test();
        $display("Checks done %0d, failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (6) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        test_refused();
        test_sub();
        test_rotate();
        test_refused();
        test_reset();
        test_rotate();
        end_of_test();
    end
    // About fifty times the expected run
    initial begin
        #100000;
        failures++;
        end_of_test();
    end
endmodule : rrsa_alu_bench
